/* File: src/acss_top.sv */
// Channel sequencer select: serial register target, mode logic, alert gating
`timescale 1ns/100ps

// Contract
// - Scan select 0 means manual, 1 means automatic scan; 2 and 3 reserved.
// - Manual mode takes the channel from the single-channel id, mask ignored.
// - Automatic mode takes channels from the scan channel mask.
// - The run bit only steers sequencing while scan select is automatic.
// - Run bit 4 set starts stepping enabled channels in ascending order.
// - Run bit clear stops automatic sequencing.
// - Bits 3..0 of the manual pick name the next manual channel.
// - Each scan mask bit includes its channel in the scan when set.
// - A set alert mask bit lets that channel's event flags raise alert.
// - A clear alert mask bit blocks that channel's flags from alert.
// - Per-channel function bit: 0 analog input, 1 general-purpose pin.
// - Gated event flags are the window comparator status per channel.
module acss_top
  import acss_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = ACSS_DEFAULT_ADDR
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [7:0] event_flag,
  input wire logic conv_done,
  output logic [2:0] conv_channel,
  output logic conv_channel_valid,
  output logic seq_active,
  output logic [7:0] analog_enable,
  output logic alert_out
);

  // ---------------------------------------------------------------
  // Pin synchronisation and bus condition detection
  // ---------------------------------------------------------------
  logic [1:0] line_s;
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic scl_p_d;
  logic sda_p_q;
  logic sda_p_d;
  logic bus_start;
  logic bus_stop;
  logic scl_rise;
  logic scl_fall;

  acss_pin_sync #(
    .WIDTH(2),
    .RST_VAL(2'h3)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_in({scl_i, sda_i}),
    .pin_sync(line_s)
  );

  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  // Previous levels for edge detection, taken from the settled stage only
  always_comb begin
    scl_p_d = scl_s;
    sda_p_d = sda_s;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_p_d;
      sda_p_q <= sda_p_d;
    end
  end

  // Data changing while the clock is high marks start and stop
  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;

  // ---------------------------------------------------------------
  // Register read decode
  // ---------------------------------------------------------------
  function automatic logic [7:0] reg_read(input logic [7:0] a, input acss_cfg_t c,
                                          input logic [7:0] stat);
    logic [7:0] v;
    v = 8'h00; // Unmapped pointers read zero
    case (a)
      ACSS_REG_PIN_FUNC: v = c.pin_func;
      ACSS_REG_SEQ_CFG: begin
        v[ACSS_SEQ_RUN_BIT] = c.sequence_run;
        v[ACSS_SCAN_SEL_LSB +: 2] = c.scan_select;
      end
      ACSS_REG_MANUAL: v[ACSS_CHID_LSB +: 4] = c.single_channel_id;
      ACSS_REG_SCAN_MASK: v = c.scan_channel_mask;
      ACSS_REG_ALERT_MASK: v = c.alert_channel_mask;
      ACSS_REG_SEQ_STATUS: v = stat;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // ---------------------------------------------------------------
  // Serial target state
  // ---------------------------------------------------------------
  acss_bus_state_t st_q;
  acss_bus_state_t st_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [3:0] bit_cnt_q;
  logic [3:0] bit_cnt_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic drive_low_q;
  logic drive_low_d;
  logic read_q;
  logic read_d;
  logic nack_q;
  logic nack_d;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  acss_cfg_t cfg_q;
  acss_cfg_t cfg_d;
  logic [7:0] status_byte;

  // Byte engine: samples on clock rise, changes the data line on clock fall
  always_comb begin
    st_d = st_q;
    shift_d = shift_q;
    bit_cnt_d = bit_cnt_q;
    ptr_d = ptr_q;
    drive_low_d = drive_low_q;
    read_d = read_q;
    nack_d = nack_q;
    wr_stb = 1'b0;
    wr_addr = ptr_q;
    wr_data = shift_q;
    if (bus_start) begin
      st_d = ACSS_ST_ADDR;
      bit_cnt_d = 4'h0;
      drive_low_d = 1'b0;
    end else if (bus_stop) begin
      st_d = ACSS_ST_IDLE;
      drive_low_d = 1'b0;
    end else if (scl_rise) begin
      unique case (st_q)
        ACSS_ST_ADDR, ACSS_ST_PTR, ACSS_ST_WDATA: begin
          shift_d = {shift_q[6:0], sda_s};
          bit_cnt_d = bit_cnt_q + 4'h1;
        end
        ACSS_ST_RDATA: bit_cnt_d = bit_cnt_q + 4'h1;
        ACSS_ST_RDATA_ACK: nack_d = sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (st_q)
        ACSS_ST_ADDR: begin
          if (bit_cnt_q == ACSS_BITS_PER_BYTE) begin
            if (shift_q[7:1] == TARGET_ADDR) begin
              st_d = ACSS_ST_ADDR_ACK;
              read_d = shift_q[0];
              drive_low_d = 1'b1;
            end else begin
              st_d = ACSS_ST_IDLE; // Not addressed: stay off the bus
            end
          end
        end
        ACSS_ST_ADDR_ACK: begin
          bit_cnt_d = 4'h0;
          if (read_q) begin
            st_d = ACSS_ST_RDATA;
            shift_d = reg_read(ptr_q, cfg_q, status_byte);
            drive_low_d = ~shift_d[7];
          end else begin
            st_d = ACSS_ST_PTR;
            drive_low_d = 1'b0;
          end
        end
        ACSS_ST_PTR: begin
          if (bit_cnt_q == ACSS_BITS_PER_BYTE) begin
            ptr_d = shift_q;
            st_d = ACSS_ST_PTR_ACK;
            drive_low_d = 1'b1;
          end
        end
        ACSS_ST_PTR_ACK, ACSS_ST_WDATA_ACK: begin
          st_d = ACSS_ST_WDATA;
          bit_cnt_d = 4'h0;
          drive_low_d = 1'b0;
        end
        ACSS_ST_WDATA: begin
          if (bit_cnt_q == ACSS_BITS_PER_BYTE) begin
            wr_stb = 1'b1;
            ptr_d = ptr_q + 8'h01; // Burst writes walk up the map
            st_d = ACSS_ST_WDATA_ACK;
            drive_low_d = 1'b1;
          end
        end
        ACSS_ST_RDATA: begin
          if (bit_cnt_q == ACSS_BITS_PER_BYTE) begin
            st_d = ACSS_ST_RDATA_ACK;
            ptr_d = ptr_q + 8'h01;
            drive_low_d = 1'b0; // Release for the controller's acknowledge
          end else begin
            shift_d = {shift_q[6:0], 1'b0};
            drive_low_d = ~shift_q[6];
          end
        end
        ACSS_ST_RDATA_ACK: begin
          bit_cnt_d = 4'h0;
          if (nack_q) begin
            st_d = ACSS_ST_IDLE; // Controller is done reading
          end else begin
            st_d = ACSS_ST_RDATA;
            shift_d = reg_read(ptr_q, cfg_q, status_byte);
            drive_low_d = ~shift_d[7];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ACSS_ST_IDLE;
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      ptr_q <= 8'h00;
      drive_low_q <= 1'b0;
      read_q <= 1'b0;
      nack_q <= 1'b1;
    end else begin
      st_q <= st_d;
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_d;
      ptr_q <= ptr_d;
      drive_low_q <= drive_low_d;
      read_q <= read_d;
      nack_q <= nack_d;
    end
  end

  // Open-drain data line: only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe = drive_low_q;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Writable bits are masked so reserved positions stay zero
  always_comb begin
    cfg_d = cfg_q;
    if (wr_stb) begin
      case (wr_addr)
        ACSS_REG_PIN_FUNC: cfg_d.pin_func = wr_data;
        ACSS_REG_SEQ_CFG: begin
          cfg_d.sequence_run = wr_data[ACSS_SEQ_RUN_BIT];
          cfg_d.scan_select = wr_data[ACSS_SCAN_SEL_LSB +: 2];
        end
        ACSS_REG_MANUAL: cfg_d.single_channel_id = wr_data[ACSS_CHID_LSB +: 4];
        ACSS_REG_SCAN_MASK: cfg_d.scan_channel_mask = wr_data;
        ACSS_REG_ALERT_MASK: cfg_d.alert_channel_mask = wr_data;
        default: ; // Read-only and unmapped pointers ignore writes
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q.pin_func <= ACSS_RST_PIN_FUNC;
      cfg_q.sequence_run <= ACSS_RST_SEQ_CFG[ACSS_SEQ_RUN_BIT];
      cfg_q.scan_select <= ACSS_RST_SEQ_CFG[ACSS_SCAN_SEL_LSB +: 2];
      cfg_q.single_channel_id <= ACSS_RST_MANUAL[ACSS_CHID_LSB +: 4];
      cfg_q.scan_channel_mask <= ACSS_RST_SCAN_MASK;
      cfg_q.alert_channel_mask <= ACSS_RST_ALERT_MASK;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // ---------------------------------------------------------------
  // Channel selection
  // ---------------------------------------------------------------
  logic mode_auto;
  logic mode_manual;
  logic [2:0] scan_chan;
  logic scan_active;
  logic [2:0] chan_q;
  logic [2:0] chan_d;
  logic chan_valid_q;
  logic chan_valid_d;
  logic alert_q;
  logic alert_d;

  // Reserved scan select codes select nothing at all
  assign mode_manual = (cfg_q.scan_select == ACSS_SCAN_MANUAL);
  assign mode_auto = (cfg_q.scan_select == ACSS_SCAN_AUTO);

  acss_scan_step #(
    .N_CH(ACSS_CHAN_COUNT),
    .CW(3)
  ) u_scan_step (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .scan_enable(mode_auto & cfg_q.sequence_run),
    .scan_mask(cfg_q.scan_channel_mask),
    .advance(conv_done),
    .scan_chan(scan_chan),
    .scan_active(scan_active)
  );

  // Manual pick ignores the scan mask; codes 8 and above give no valid channel.
  // A manually picked pin configured as general-purpose is also flagged invalid so the
  // converter does not report a meaningless result for it; the automatic scan does not check pin function.
  always_comb begin
    chan_d = 3'h0;
    chan_valid_d = 1'b0;
    if (mode_manual) begin
      chan_d = cfg_q.single_channel_id[2:0];
      chan_valid_d = ~cfg_q.single_channel_id[3]
                     & ~cfg_q.pin_func[cfg_q.single_channel_id[2:0]];
    end else if (mode_auto && scan_active) begin
      chan_d = scan_chan;
      chan_valid_d = 1'b1;
    end
    alert_d = |(event_flag & cfg_q.alert_channel_mask);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      chan_q <= 3'h0;
      chan_valid_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      chan_q <= chan_d;
      chan_valid_q <= chan_valid_d;
      alert_q <= alert_d;
    end
  end

  // Status byte shows what the selector is doing right now
  always_comb begin
    status_byte = 8'h00;
    status_byte[ACSS_STAT_ACTIVE_BIT] = scan_active;
    status_byte[ACSS_STAT_VALID_BIT] = chan_valid_q;
    status_byte[2:0] = chan_q;
  end

  assign conv_channel = chan_q;
  assign conv_channel_valid = chan_valid_q;
  assign seq_active = scan_active;
  assign analog_enable = ~cfg_q.pin_func;
  assign alert_out = alert_q;

endmodule : acss_top

/* File: pkg/acss_pkg.sv */
// Package for the ADC channel sequencer select block: register map, fields, types
package acss_pkg;

  // ---------------------------------------------------------------
  // Register offsets (8-bit register pointer)
  // ---------------------------------------------------------------
  localparam logic [7:0] ACSS_REG_PIN_FUNC = 8'h05;
  localparam logic [7:0] ACSS_REG_SEQ_CFG = 8'h10;
  localparam logic [7:0] ACSS_REG_MANUAL = 8'h11;
  localparam logic [7:0] ACSS_REG_SCAN_MASK = 8'h12;
  localparam logic [7:0] ACSS_REG_ALERT_MASK = 8'h14;
  localparam logic [7:0] ACSS_REG_SEQ_STATUS = 8'h1F;

  // ---------------------------------------------------------------
  // Field positions, writable-bit masks and reset values
  // ---------------------------------------------------------------
  localparam int ACSS_SEQ_RUN_BIT = 4;
  localparam int ACSS_SCAN_SEL_LSB = 0;
  localparam int ACSS_CHID_LSB = 0;
  localparam int ACSS_STAT_ACTIVE_BIT = 7;
  localparam int ACSS_STAT_VALID_BIT = 3;
  localparam logic [7:0] ACSS_SEQ_CFG_WMASK = 8'h13;
  localparam logic [7:0] ACSS_MANUAL_WMASK = 8'h0F;
  localparam logic [7:0] ACSS_RST_PIN_FUNC = 8'h00;
  localparam logic [7:0] ACSS_RST_SEQ_CFG = 8'h00;
  localparam logic [7:0] ACSS_RST_MANUAL = 8'h00;
  localparam logic [7:0] ACSS_RST_SCAN_MASK = 8'h00;
  localparam logic [7:0] ACSS_RST_ALERT_MASK = 8'h00;

  // Scan select codes; 2 and 3 are reserved
  localparam logic [1:0] ACSS_SCAN_MANUAL = 2'h0;
  localparam logic [1:0] ACSS_SCAN_AUTO = 2'h1;

  // Channel count and serial framing
  localparam int ACSS_CHAN_COUNT = 8;
  localparam logic [3:0] ACSS_BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] ACSS_DEFAULT_ADDR = 7'h2A; // Arbitrary neutral target address

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pin_func;      // 1 = general-purpose pin, 0 = analog input
    logic sequence_run;
    logic [1:0] scan_select;
    logic [3:0] single_channel_id;
    logic [7:0] scan_channel_mask;
    logic [7:0] alert_channel_mask;
  } acss_cfg_t;

  typedef enum logic [3:0] {
    ACSS_ST_IDLE = 4'h0,
    ACSS_ST_ADDR = 4'h1,
    ACSS_ST_ADDR_ACK = 4'h2,
    ACSS_ST_PTR = 4'h3,
    ACSS_ST_PTR_ACK = 4'h4,
    ACSS_ST_WDATA = 4'h5,
    ACSS_ST_WDATA_ACK = 4'h6,
    ACSS_ST_RDATA = 4'h7,
    ACSS_ST_RDATA_ACK = 4'h8
  } acss_bus_state_t;

endpackage : acss_pkg

/* File: src/acss_pin_sync.sv */
// Two-flip-flop synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/100ps
module acss_pin_sync
  import acss_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  // ---------------------------------------------------------------
  // Synchroniser stages
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stab_q;
  logic [WIDTH-1:0] stab_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = pin_in;
    stab_d = meta_q;
  end

  // Idle bus lines are high, so reset to the idle level
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= RST_VAL;
      stab_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      stab_q <= stab_d;
    end
  end

  assign pin_sync = stab_q;

endmodule : acss_pin_sync

/* File: src/acss_scan_step.sv */
// Automatic scan stepper: walks enabled channels in ascending order with wrap
`timescale 1ns/100ps
module acss_scan_step
  import acss_pkg::*;
#(
  parameter int N_CH = ACSS_CHAN_COUNT,
  parameter int CW = $clog2(N_CH)
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic scan_enable,
  input wire logic [N_CH-1:0] scan_mask,
  input wire logic advance,
  output logic [CW-1:0] scan_chan,
  output logic scan_active
);

  // Lowest enabled channel strictly after 'from', wrapping past the top
  function automatic logic [CW-1:0] next_on(input logic [N_CH-1:0] m,
                                            input logic [CW-1:0] from);
    logic [CW-1:0] pick;
    int k;
    pick = from;
    k = 0;
    for (int i = N_CH; i >= 1; i--) begin
      k = (int'(from) + i) % N_CH;
      if (m[k]) begin
        pick = CW'(k);
      end
    end
    return pick;
  endfunction : next_on

  // ---------------------------------------------------------------
  // Stepper state
  // ---------------------------------------------------------------
  logic [CW-1:0] chan_q;
  logic [CW-1:0] chan_d;
  logic active_q;
  logic active_d;

  // Start from the lowest enabled channel, then step on each finished conversion
  always_comb begin
    chan_d = chan_q;
    active_d = active_q;
    if (!scan_enable || scan_mask == '0) begin
      active_d = 1'b0;
    end else if (!active_q) begin
      active_d = 1'b1;
      chan_d = next_on(scan_mask, CW'(N_CH - 1));
    end else if (advance) begin
      chan_d = next_on(scan_mask, chan_q);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      chan_q <= '0;
      active_q <= 1'b0;
    end else begin
      chan_q <= chan_d;
      active_q <= active_d;
    end
  end

  assign scan_chan = chan_q;
  assign scan_active = active_q;

endmodule : acss_scan_step

/* File: tb/acss_top_assertions.sv */
// Port-level concurrent checks for the channel sequencer select block
`timescale 1ns/100ps
module acss_top_assertions (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [7:0] event_flag,
  input wire logic conv_done,
  input wire logic [2:0] conv_channel,
  input wire logic conv_channel_valid,
  input wire logic seq_active,
  input wire logic [7:0] analog_enable,
  input wire logic alert_out
);
  // ---------------------------------------------------------------
  // One clock domain: shared clocking and reset
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Alert follows gated flags; a quiet bus and quiet flags leave it alone
  property p_alert_quiet;
    event_flag == 8'h00 |=> !alert_out;
  endproperty
  a_alert_quiet: assert property (p_alert_quiet) else $error("alert with no flag");
  property p_alert_hold;
    ($stable(scl_i) && $stable(event_flag)) [*8] |=> $stable(alert_out);
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert moved alone");
  // Outside scanning the channel only moves through the register bus
  property p_man_hold;
    (!seq_active && !conv_done && $stable(scl_i)) [*8] |=>
      $stable(conv_channel) && $stable(conv_channel_valid);
  endproperty
  a_man_hold: assert property (p_man_hold) else $error("manual channel moved");
  property p_scan_valid;
    seq_active ##1 seq_active |-> conv_channel_valid;
  endproperty
  a_scan_valid: assert property (p_scan_valid) else $error("scan without valid");
  property p_scan_start;
    $rose(seq_active) |=> conv_channel_valid;
  endproperty
  a_scan_start: assert property (p_scan_start) else $error("start not valid");
  // The stepper only moves two cycles after an advance request
  property p_scan_hold;
    seq_active [*3] ##0 !$past(conv_done, 2) |-> $stable(conv_channel);
  endproperty
  a_scan_hold: assert property (p_scan_hold) else $error("scan moved unasked");
  property p_ack_stand;
    $rose(sda_oe) |-> sda_oe [*4];
  endproperty
  a_ack_stand: assert property (p_ack_stand) else $error("data drive too short");
  // Data drive may only move while the clock is low, else it forges a start or stop
  property p_drive_low;
    scl_i |-> $stable(sda_oe) && !sda_o;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("data drive moved in clock high");

  c_scan: cover property ($rose(seq_active));
  c_alert: cover property ($rose(alert_out));
  c_ack: cover property ($rose(sda_oe));
endmodule : acss_top_assertions

bind acss_top acss_top_assertions i_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .event_flag(event_flag), .conv_done(conv_done),
  .conv_channel(conv_channel), .conv_channel_valid(conv_channel_valid),
  .seq_active(seq_active), .analog_enable(analog_enable), .alert_out(alert_out)
);

/* File: tb/acss_host_model.sv */
// Two-wire bus controller model that reaches the block's registers
`timescale 1ns/100ps
module acss_host_model
  import acss_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  logic [6:0] addr = ACSS_DEFAULT_ADDR;
  logic acked = 1'h0;
  initial begin
    scl = 1'h1;
    sda_pull = 1'h0;
  end
  // Set both lines, then wait; 6-cycle phases keep clear of the 4-cycle minimum
  task automatic step(input logic c, input logic p, input int n);
    scl = c;
    sda_pull = p;
    repeat (n) @(negedge clk_sys);
  endtask : step
  // Data changes only while the clock is low, so no false start or stop
  task automatic bitx(input logic b, output logic r);
    step(1'h0, !b, 6);
    step(1'h1, !b, 6);
    r = sda;
    step(1'h0, !b, 2);
  endtask : bitx
  task automatic start;
    acked = 1'h1;
    step(1'h0, 1'h0, 4);
    step(1'h1, 1'h0, 6);
    step(1'h1, 1'h1, 6);
    step(1'h0, 1'h1, 2);
  endtask : start
  task automatic stop;
    step(1'h0, 1'h1, 4);
    step(1'h1, 1'h1, 6);
    step(1'h1, 1'h0, 6);
  endtask : stop
  task automatic put(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'h1, r);
    acked = acked & !r;
  endtask : put
  // A read byte is always closed with a not-acknowledge
  task automatic get(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'h1, r);
      d[i] = r;
    end
    bitx(1'h1, r);
  endtask : get
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    start();
    put({addr, 1'h0});
    put(p);
    put(d);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    start();
    put({addr, 1'h0});
    put(p);
    start();
    put({addr, 1'h1});
    get(d);
    stop();
  endtask : rd
endmodule : acss_host_model

/* File: tb/testbench.sv */
// Self-checking bench: bus host, converter stub and alert flags against a model
`timescale 1ns/100ps
module testbench;
  import acss_pkg::*;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic scl, sda_pull, sda_o, sda_oe, sda, conv_channel_valid, seq_active, alert_out;
  logic conv_done = 1'h0;
  logic [7:0] event_flag = 8'h00;
  logic [2:0] conv_channel;
  logic [7:0] analog_enable, rd;
  logic [7:0] m_cfg = 8'h00, m_id = 8'h00, m_scan = 8'h00, m_alert = 8'h00, m_pin = 8'h00;
  logic [31:0] seed = 32'h00007F8F;
  logic [7:0] regs[5] = '{ACSS_REG_SEQ_CFG, ACSS_REG_MANUAL, ACSS_REG_SCAN_MASK,
                          ACSS_REG_ALERT_MASK, 8'h13};
  logic [7:0] cfgs[5] = '{8'h10, 8'h01, 8'h12, 8'h13, 8'h00};
  int c_scan = 0;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;

  // Open-drain data line with pull-up
  assign sda = !(sda_pull || (sda_oe && !sda_o));
  acss_top i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .event_flag(event_flag), .conv_done(conv_done),
    .conv_channel(conv_channel), .conv_channel_valid(conv_channel_valid),
    .seq_active(seq_active), .analog_enable(analog_enable), .alert_out(alert_out));
  acss_host_model i_host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  // Hang guard, well above the roughly 26k cycles the sequence needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // Reference model and compare tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic on();
    return m_cfg[1:0] == 2'h1 && m_cfg[4] && m_scan != 8'h00;
  endfunction : on
  // Next enabled channel upward, wrapping past the top
  function automatic int nxt(input int c);
    for (int k = 1; k <= 8; k++) if (m_scan[(c + k) % 8]) return (c + k) % 8;
    return c;
  endfunction : nxt
  task automatic bad(input string s);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, s);
  endtask : bad
  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) bad($sformatf("byte got %h exp %h", g, e));
  endtask : cmp_reg
  task automatic cmp_bit(input logic g, input logic e);
    checks++;
    if (g !== e) bad($sformatf("bit got %b exp %b", g, e));
  endtask : cmp_bit
  task automatic cmp_sel(input logic [4:0] g, input logic [4:0] e, input logic [4:0] k);
    checks++;
    if ((g & k) !== (e & k)) bad($sformatf("select got %h exp %h", g, e));
  endtask : cmp_sel
  // Channel is only meaningful while valid is expected
  task automatic chk_sel;
    logic [4:0] e;
    logic [4:0] k;
    k = 5'h1F;
    e = 5'h00;
    if (on()) e = {2'h3, 3'(c_scan)};
    else if (m_cfg[1:0] == 2'h0 && m_id < 8 && !m_pin[m_id[2:0]]) e = {2'h1, m_id[2:0]};
    else k = 5'h18;
    cmp_sel({seq_active, conv_channel_valid, conv_channel}, e, k);
  endtask : chk_sel
  // Register write; the model keeps only the writable bits
  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    logic was;
    was = on();
    i_host.wr(p, d);
    if (p == ACSS_REG_SEQ_CFG) m_cfg = d & 8'h13;
    if (p == ACSS_REG_MANUAL) m_id = d & 8'h0F;
    if (p == ACSS_REG_SCAN_MASK) m_scan = d;
    if (p == ACSS_REG_ALERT_MASK) m_alert = d;
    if (p == ACSS_REG_PIN_FUNC) m_pin = d;
    if (on() && !was) c_scan = nxt(7);
    repeat (4) @(negedge clk_sys);
  endtask : wreg
  // Conversion-done held n cycles gives n back-to-back advances
  task automatic pulse(input int n);
    conv_done = 1'h1;
    repeat (n) @(negedge clk_sys);
    conv_done = 1'h0;
    repeat (3) @(negedge clk_sys);
    repeat (n) if (on()) c_scan = nxt(c_scan);
  endtask : pulse
  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'h0;
    repeat (4) @(negedge clk_sys);
    chk_sel();
    foreach (regs[i]) begin
      i_host.rd(regs[i], rd);
      cmp_reg(rd, 8'h00);
    end
    // Reserved bits and an unmapped pointer must swallow writes
    wreg(ACSS_REG_SEQ_CFG, 8'hEC);
    wreg(ACSS_REG_MANUAL, 8'hF5);
    cmp_bit(i_host.acked, 1'h1);
    wreg(8'h13, 8'hFF);
    foreach (regs[i]) begin
      i_host.rd(regs[i], rd);
      cmp_reg(rd, (i == 1) ? 8'h05 : 8'h00);
    end
    // Channel 3 as a general-purpose pin; every id code, mask ignored
    wreg(ACSS_REG_PIN_FUNC, 8'h08);
    cmp_reg(analog_enable, 8'hF7);
    wreg(ACSS_REG_SCAN_MASK, 8'(rnd()) | 8'h80);
    for (int i = 0; i < 16; i++) begin
      wreg(ACSS_REG_MANUAL, 8'(i));
      pulse(1);
      chk_sel();
    end
    wreg(ACSS_REG_PIN_FUNC, 8'h00);
    foreach (cfgs[i]) begin
      wreg(ACSS_REG_SEQ_CFG, cfgs[i]);
      chk_sel();
    end
    // Scans over random masks, a mask change mid-run, then a stop
    for (int j = 0; j < 3; j++) begin
      wreg(ACSS_REG_SCAN_MASK, 8'(rnd()) | 8'h80);
      wreg(ACSS_REG_SEQ_CFG, 8'h11);
      chk_sel();
      i_host.rd(ACSS_REG_SEQ_STATUS, rd);
      cmp_reg(rd, {5'h11, 3'(c_scan)});
      for (int k = 0; k < 12; k++) begin
        if (k == 6) wreg(ACSS_REG_SCAN_MASK, 8'(rnd()) | 8'h01);
        pulse(int'(rnd() & 32'h1) + 1);
        chk_sel();
      end
      wreg(ACSS_REG_SEQ_CFG, 8'h01);
      pulse(1);
      chk_sel();
    end
    for (int j = 0; j < 24; j++) begin
      if (j % 8 == 0) wreg(ACSS_REG_ALERT_MASK, 8'(rnd()));
      event_flag = 8'(rnd());
      @(negedge clk_sys);
      cmp_bit(alert_out, |(event_flag & m_alert));
    end
    // A foreign target address gets no acknowledge and changes nothing
    i_host.addr = ACSS_DEFAULT_ADDR ^ 7'h01;
    i_host.wr(ACSS_REG_ALERT_MASK, 8'h5A);
    cmp_bit(i_host.acked, 1'h0);
    i_host.addr = ACSS_DEFAULT_ADDR;
    i_host.rd(ACSS_REG_ALERT_MASK, rd);
    cmp_reg(rd, m_alert);
    results();
  end
endmodule : testbench
